// [src/sensor_port_regs.svh]
// Purpose: register offsets, field positions, reset values and timing counts of the sensor output port
// Assumes: included by its bare name
// Notes: offsets are byte addresses on the register bus
`ifndef SENSOR_PORT_REGS_SVH
`define SENSOR_PORT_REGS_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_GEOM 8'h08
`define OFS_FRAMES 8'h0C
`define CTRL_DARK_ROWS 2
`define CTRL_DARK_COLS 3
`define CTRL_COMPAND 4
`define CTRL_STEREO 5
`define CTRL_FLIP_COL 6
`define CTRL_FLIP_ROW 7
`define CTRL_RESET 8'h00
`define STAT_ERR 0
`define ARRAY_COLS 16'h0329
`define ARRAY_ROWS 16'h01F3
`define ACT_COLS 753
`define ACT_ROWS 481
`define OUT_COLS 752
`define OUT_ROWS 480
`define DARK_ROWS 3
`define DARK_COLS 36
`define H_BLANK 94
`define V_BLANK_ROWS 45
`define SER_BITS 5'h10
`endif

// [src/sensor_port_pkg.sv]
// Purpose: types shared by the sensor output port
// Assumes: nothing
// Notes: state of each clock domain is one packed struct
package sensor_port_pkg;
  typedef enum logic [1:0] {MODE_MASTER = 2'b00, MODE_SNAP = 2'b01, MODE_SLAVE = 2'b10} mode_e;
  typedef enum logic [1:0] {F_IDLE = 2'b00, F_ROWS = 2'b01, F_VBLANK = 2'b10} frame_e;
  typedef struct packed {logic frame_qual; logic row_qual; logic [9:0] pixel_word_bus;} pix_s;
  typedef struct packed {logic row_start_sync; logic frame_start_sync;} sync_s;
  typedef struct packed {logic [7:0] sh; logic [2:0] cnt; logic [7:0] hold; logic tog;} link_s;
  typedef struct packed {
    logic oe_s1, oe_s2, stb_s1, stb_s2, exp_s1, exp_s2, exp_s3;
    sync_s syn_s1, syn_s2, syn_s3;
    logic [1:0] id_s1, id_s2;
    logic tg_s1, tg_s2, tg_s3;
    logic [7:0] ctrl;
    logic err;
    logic [15:0] frames;
    logic aw_got, w_got, awready, wready, bvalid, arready, rvalid;
    logic [7:0] aw_addr;
    logic [31:0] w_data, rdata;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp;
    frame_e fst;
    logic start_pend, row_pend, pclk, pix_oe, array_dark;
    logic [10:0] col, row, array_col, array_row;
    pix_s pix;
    sync_s sync_out, sync_oe;
    logic [6:0] bus_id;
    logic [15:0] ser_sh;
    logic [4:0] ser_cnt;
    logic sclk, sdat;
    logic [7:0] own_byte, p_byte;
    logic p_pend;
  } state_s;
endpackage

// [src/sensor_port.sv]
// Purpose: pixel output port of a global-shutter sensor with frame timing, sync pins and stereo merge
// Assumes: aclk is the master clock; adc_sample is valid at each pixel advance
// Notes: three-state pins come out as level plus enable; the pad ring does the rest
// How it works
// - pixel word changes on pixel clock falling edge, so it is steady at the rising edge
// - output enable low puts word, qualifiers and pixel clock in high impedance
// - snapshot and slave modes start a frame on a rising exposure trigger edge
// - active-low reset acts without a clock and restores every register default
// - standby stops frame generation at once
// - master drives row and frame start pulses; slave takes them as inputs
// - error output mirrors the stereo error flag
// - two select pins choose the control bus identity
// - stereo master merges its own and the partner byte into one serial stream
// - array 809 by 499, active 753 by 481, output 752 by 480
// - show-dark-rows adds three black rows at the top of the frame
// - show-dark-columns adds the 36 dark columns to each row
// - mirrored readout uses the extra column and row to start on the same pixel
// - pixels come out as 10 bits or as 12 bits companded to 10 bits
// - reset defaults give free-running full frames
// - with row qualifier high a new word comes every pixel clock period
// - pixel clock runs always, blanking included
`include "sensor_port_regs.svh"
module sensor_port #(
  parameter int OUT_COLS = `OUT_COLS,
  parameter int OUT_ROWS = `OUT_ROWS,
  parameter int H_BLANK = `H_BLANK,
  parameter int V_BLANK_ROWS = `V_BLANK_ROWS,
  parameter logic [6:0] BUS_ID_BASE = 7'h48 // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic output_drive_en,
  input wire logic standby,
  input wire logic exposure,
  input wire logic bus_id_select_0,
  input wire logic bus_id_select_1,
  input wire logic [11:0] adc_sample,
  output logic [10:0] array_col,
  output logic [10:0] array_row,
  output logic array_dark,
  output sensor_port_pkg::pix_s pixel_out,
  output logic pixel_clock_out,
  output logic pixel_out_en,
  input wire sensor_port_pkg::sync_s sync_in,
  output sensor_port_pkg::sync_s sync_out,
  output sensor_port_pkg::sync_s sync_oe,
  output logic error_out,
  output logic [6:0] bus_id,
  input wire logic partner_shift_clock_in_pos,
  input wire logic partner_shift_clock_in_neg,
  input wire logic partner_serial_in_pos,
  input wire logic partner_serial_in_neg,
  output logic serial_shift_clock_out_pos,
  output logic serial_shift_clock_out_neg,
  output logic serial_stream_out_pos,
  output logic serial_stream_out_neg
);
  import sensor_port_pkg::*;

  state_s s, n;
  link_s l, ln;

  // 12-bit sample folded into 10 bits, fine steps at the dark end
  function automatic logic [9:0] compand(input logic [11:0] x);
    if (x < 12'h100) begin
      compand = x[9:0];
    end else if (x < 12'h400) begin
      compand = 10'h100 + 10'((x - 12'h100) >> 1);
    end else begin
      compand = 10'h280 + 10'((x - 12'h400) >> 3);
    end
  endfunction

  // partner link: deserialise bytes on the partner shift clock, hand over by toggle
  always_comb begin
    ln = l;
    ln.sh = {l.sh[6:0], partner_serial_in_pos};
    ln.cnt = l.cnt + 3'h1;
    if (l.cnt == 3'h7) begin
      ln.hold = {l.sh[6:0], partner_serial_in_pos};
      ln.tog = ~l.tog;
    end
  end

  always_ff @(posedge partner_shift_clock_in_pos or negedge aresetn) begin
    if (!aresetn) begin
      l <= '0;
    end else begin
      l <= ln;
    end
  end

  // main domain next state
  always_comb begin
    logic [10:0] width, height, row_len, c, r;
    logic exp_rise, fs_rise, rs_rise, wr_go, wr_ok, ar_ok, vpos;
    mode_e mode;
    width = 11'(OUT_COLS);
    height = 11'(OUT_ROWS);
    row_len = '0;
    c = '0;
    r = '0;
    wr_go = 1'b0;
    wr_ok = 1'b0;
    ar_ok = 1'b0;
    vpos = 1'b0;
    exp_rise = 1'b0;
    fs_rise = 1'b0;
    rs_rise = 1'b0;
    mode = MODE_MASTER;
    n = s;
    // two-flop synchronisers for pins and the link toggle
    n.oe_s1 = output_drive_en;
    n.oe_s2 = s.oe_s1;
    n.stb_s1 = standby;
    n.stb_s2 = s.stb_s1;
    n.exp_s1 = exposure;
    n.exp_s2 = s.exp_s1;
    n.exp_s3 = s.exp_s2;
    n.syn_s1 = sync_in;
    n.syn_s2 = s.syn_s1;
    n.syn_s3 = s.syn_s2;
    n.id_s1 = {bus_id_select_1, bus_id_select_0};
    n.id_s2 = s.id_s1;
    n.tg_s1 = l.tog;
    n.tg_s2 = s.tg_s1;
    n.tg_s3 = s.tg_s2;
    exp_rise = s.exp_s2 & ~s.exp_s3;
    fs_rise = s.syn_s2.frame_start_sync & ~s.syn_s3.frame_start_sync;
    rs_rise = s.syn_s2.row_start_sync & ~s.syn_s3.row_start_sync;
    n.pix_oe = s.oe_s2;
    n.bus_id = BUS_ID_BASE | {5'h00, s.id_s2};
    mode = (s.ctrl[1:0] == 2'b01) ? MODE_SNAP : (s.ctrl[1:0] == 2'b10) ? MODE_SLAVE : MODE_MASTER;
    if (s.ctrl[`CTRL_DARK_COLS]) begin
      width = width + 11'(`DARK_COLS);
    end
    if (s.ctrl[`CTRL_DARK_ROWS]) begin
      height = height + 11'(`DARK_ROWS);
    end
    row_len = width + 11'(H_BLANK);
    // exposure trigger and slave frame sync are latched until a frame starts; slave row sync until it ends a row
    if (mode != MODE_MASTER && (exp_rise || (mode == MODE_SLAVE && fs_rise))) begin
      n.start_pend = 1'b1;
    end
    if (mode == MODE_SLAVE && rs_rise) begin
      n.row_pend = 1'b1;
    end
    // pixel clock free runs at half the master clock
    n.pclk = ~s.pclk;
    if (s.pclk) begin
      n.sync_out = '0;
      unique case (s.fst)
        F_IDLE: begin
          if (!s.stb_s2 && (mode == MODE_MASTER || s.start_pend)) begin
            n.fst = F_ROWS;
            n.col = '0;
            n.row = '0;
            n.start_pend = 1'b0;
            n.frames = s.frames + 16'h0001;
            n.sync_out = '{row_start_sync: 1'b1, frame_start_sync: 1'b1};
          end
        end
        F_ROWS, F_VBLANK: begin
          n.col = s.col + 11'h001;
          if (s.col >= row_len - 11'h001 || s.row_pend) begin
            n.col = '0;
            n.row_pend = 1'b0;
            n.row = s.row + 11'h001;
            if (s.fst == F_ROWS && s.row >= height - 11'h001) begin
              n.fst = F_VBLANK;
              n.row = '0;
            end else if (s.fst == F_VBLANK && s.row == 11'(V_BLANK_ROWS - 1)) begin
              n.fst = F_IDLE;
            end
            n.sync_out.row_start_sync = (n.fst == F_ROWS);
          end
        end
        default: n.fst = F_IDLE;
      endcase
      // output describes the position just left; the address shows the one entered
      vpos = s.fst == F_ROWS && !s.stb_s2 && s.col < width;
      n.pix.frame_qual = s.fst == F_ROWS && !s.stb_s2;
      n.pix.row_qual = vpos;
      n.pix.pixel_word_bus = !vpos ? 10'h000 : s.ctrl[`CTRL_COMPAND] ? compand(adc_sample) : adc_sample[11:2];
      if (vpos) begin
        n.own_byte = n.pix.pixel_word_bus[9:2];
      end
      c = n.col;
      r = n.row;
      n.array_dark = 1'b0;
      if (s.ctrl[`CTRL_DARK_COLS]) begin
        n.array_dark = c < 11'(`DARK_COLS);
        c = n.array_dark ? c : c - 11'(`DARK_COLS);
      end
      if (s.ctrl[`CTRL_DARK_ROWS]) begin
        n.array_dark = n.array_dark | (r < 11'(`DARK_ROWS));
        r = (r < 11'(`DARK_ROWS)) ? r : r - 11'(`DARK_ROWS);
      end
      // mirrored readout runs from the spare column and row down to index 1
      n.array_col = (s.ctrl[`CTRL_FLIP_COL] && !n.array_dark) ? 11'(`ACT_COLS - 1) - c : c;
      n.array_row = (s.ctrl[`CTRL_FLIP_ROW] && !n.array_dark) ? 11'(`ACT_ROWS - 1) - r : r;
    end
    // standby halts frame generation immediately
    if (s.stb_s2) begin
      n.fst = F_IDLE;
      n.sync_out = '0;
      n.start_pend = 1'b0;
      n.row_pend = 1'b0;
    end
    n.sync_oe = (mode == MODE_MASTER) ? 2'b11 : 2'b00;
    if (mode != MODE_MASTER) begin
      n.sync_out = '0;
    end
    // partner byte arrival; an unsent byte overwritten is a stereo error
    if (s.tg_s2 != s.tg_s3) begin
      n.p_byte = l.hold;
      n.p_pend = 1'b1;
      if (s.p_pend && s.ctrl[`CTRL_STEREO]) begin
        n.err = 1'b1;
      end
    end
    // serial merge: own byte then partner byte, data moves on shift clock falling edge
    if (s.ser_cnt != 5'h00) begin
      n.sclk = ~s.sclk;
      if (s.sclk) begin
        n.sdat = s.ser_sh[15];
        n.ser_sh = {s.ser_sh[14:0], 1'b0};
        n.ser_cnt = s.ser_cnt - 5'h01;
      end
    end else if (s.ctrl[`CTRL_STEREO] && s.p_pend && !(s.tg_s2 != s.tg_s3)) begin
      // first bit goes out with the clock low, so every bit meets exactly one rising edge
      n.sdat = s.own_byte[7];
      n.ser_sh = {s.own_byte[6:0], s.p_byte, 1'b0};
      n.ser_cnt = `SER_BITS;
      n.p_pend = 1'b0;
      n.sclk = 1'b0;
    end else begin
      n.sclk = 1'b0;
      n.sdat = 1'b0;
    end
    // register bus write: address and data in either order, answer after both
    if (awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    wr_go = s.aw_got && s.w_got && !s.bvalid;
    if (wr_go) begin
      wr_ok = 1'b1;
      if (s.aw_addr == `OFS_CTRL && s.w_strb[0]) begin
        n.ctrl = s.w_data[7:0];
      end else if (s.aw_addr == `OFS_STATUS && s.w_strb[0] && s.w_data[`STAT_ERR]) begin
        n.err = n.err & (s.tg_s2 != s.tg_s3) & s.p_pend & s.ctrl[`CTRL_STEREO]; // set wins over clear
      end else if (s.aw_addr != `OFS_GEOM && s.aw_addr != `OFS_FRAMES && s.aw_addr != `OFS_CTRL
                   && s.aw_addr != `OFS_STATUS) begin
        wr_ok = 1'b0;
      end
      n.bvalid = 1'b1;
      n.bresp = wr_ok ? 2'b00 : 2'b10;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // register bus read
    if (arvalid && s.arready) begin
      ar_ok = 1'b1;
      n.rvalid = 1'b1;
      unique case (araddr)
        `OFS_CTRL: n.rdata = {24'h000000, s.ctrl};
        `OFS_STATUS: n.rdata = {16'h0000, 1'b0, s.bus_id, 3'h0, s.stb_s2, s.fst, s.p_pend, s.err};
        `OFS_GEOM: n.rdata = {`ARRAY_COLS, `ARRAY_ROWS};
        `OFS_FRAMES: n.rdata = {16'h0000, s.frames};
        default: begin
          ar_ok = 1'b0;
          n.rdata = 32'h00000000;
        end
      endcase
      n.rresp = ar_ok ? 2'b00 : 2'b10;
    end else if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;
  end

  // all main-domain state; reset loads constants without waiting for the clock
  always_ff @(posedge aclk or negedge aresetn) begin
    if (!aresetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign array_col = s.array_col;
  assign array_row = s.array_row;
  assign array_dark = s.array_dark;
  assign pixel_out = s.pix;
  assign pixel_clock_out = s.pclk;
  assign pixel_out_en = s.pix_oe;
  assign sync_out = s.sync_out;
  assign sync_oe = s.sync_oe;
  assign error_out = s.err;
  assign bus_id = s.bus_id;
  assign serial_shift_clock_out_pos = s.sclk;
  assign serial_shift_clock_out_neg = ~s.sclk;
  assign serial_stream_out_pos = s.sdat;
  assign serial_stream_out_neg = ~s.sdat;

  // checks
  a_pclk_free_run: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> pixel_clock_out != $past(pixel_clock_out)) else $error("pixel clock stalled");
  a_word_at_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(pixel_out.pixel_word_bus) |-> !pixel_clock_out) else $error("word changed on rising pixel clock");
  a_drive_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !s.oe_s2 |=> !pixel_out_en) else $error("pins driven with enable low");
  a_row_in_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    pixel_out.row_qual |-> pixel_out.frame_qual) else $error("row qualifier outside frame");
  a_standby_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s.stb_s2 ##1 clk_en ##1 clk_en |=> !pixel_out.frame_qual) else $error("frame runs in standby");
  a_snap_start: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s.ctrl[1:0] == 2'b01 && !s.stb_s2 && s.fst == F_IDLE && s.exp_s2 && !s.exp_s3 && !standby
    |=> s.start_pend) else $error("exposure edge lost");
  a_master_sync: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_out.frame_start_sync |-> sync_oe.frame_start_sync && s.fst == F_ROWS) else $error("frame sync misplaced");
  a_error_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s.ctrl[`CTRL_STEREO] && s.p_pend && s.tg_s2 != s.tg_s3 |=> error_out) else $error("error not raised");
endmodule

// [verification/stereo_partner.sv]
// Purpose: behavioural stereo partner sensor that drives the serial link into the port
// Assumes: link clock of 80 ns that only runs while a byte is being sent
// Notes: once a byte is done the data line shows the inverse of its last bit
module stereo_partner (
  output logic clk_pos,
  output logic clk_neg,
  output logic dat_pos,
  output logic dat_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels: clock stands low between bytes
  initial begin
    clk_pos = 1'b0;
    dat_pos = 1'b0;
  end
  // differential halves are the inverse of the positive halves
  assign clk_neg = ~clk_pos;
  assign dat_neg = ~dat_pos;
  // one byte msb first, data set while the clock is low, offset from the system clock
  task automatic send(input logic [7:0] b);
    #3;
    for (int i = 7; i >= 0; i--) begin
      dat_pos = b[i];
      #40;
      clk_pos = 1'b1;
      #40;
      clk_pos = 1'b0;
    end
    dat_pos = ~b[0]; // released line must not look like held data
  endtask
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench of the sensor output port
// Assumes: small frame sizes through parameters; the partner model drives the link
// Notes: register rows first, then hand-written awkward cases
`include "sensor_port_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_port_pkg::*;
  localparam int COLS = 8;
  localparam int ROWS = 4;
  localparam logic [6:0] ID_BASE = 7'h48; // arbitrary value
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic [1:0] rs;} row_s;
  logic aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic output_drive_en, standby, exposure, bus_id_select_0, bus_id_select_1, pixel_clock_out, pixel_out_en;
  logic error_out, lk_cp, lk_cn, lk_dp, lk_dn, sc_p, sc_n, sd_p, sd_n, mon_on, p_pclk, p_ssc;
  logic [11:0] adc_sample, p_adc;
  logic [10:0] array_col, array_row;
  logic array_dark, dark_seen;
  logic [6:0] bus_id;
  logic [15:0] ser_word;
  pix_s pixel_out, p_pix;
  sync_s sync_in, sync_out, sync_oe, p_sync;
  int errors, compares, wc, rc, row_words, frame_rows, frames, fs_pulses, ser_bits, f, n, word_mode;
  row_s rows [9] = '{'{1'b0, `OFS_CTRL, 32'h0, 32'h0, 2'b00}, '{1'b0, `OFS_GEOM, 32'h0, 32'h032901F3, 2'b00},
    '{1'b1, `OFS_GEOM, 32'h0, 32'h0, 2'b00}, '{1'b0, `OFS_GEOM, 32'h0, 32'h032901F3, 2'b00},
    '{1'b0, 8'h10, 32'h0, 32'h0, 2'b10}, '{1'b1, 8'h10, 32'h5, 32'h0, 2'b10},
    '{1'b1, `OFS_CTRL, 32'hFFFFFFC0, 32'h0, 2'b00}, '{1'b0, `OFS_CTRL, 32'h0, 32'h000000C0, 2'b00},
    '{1'b1, `OFS_CTRL, 32'h0, 32'h0, 2'b00}};
  sensor_port #(.OUT_COLS(COLS), .OUT_ROWS(ROWS), .H_BLANK(4), .V_BLANK_ROWS(2), .BUS_ID_BASE(ID_BASE)) dut_u (
    .aclk, .aresetn, .clk_en, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .output_drive_en, .standby,
    .exposure, .bus_id_select_0, .bus_id_select_1, .adc_sample, .array_col, .array_row, .array_dark,
    .pixel_out, .pixel_clock_out, .pixel_out_en, .sync_in, .sync_out, .sync_oe, .error_out, .bus_id,
    .partner_shift_clock_in_pos(lk_cp), .partner_shift_clock_in_neg(lk_cn), .partner_serial_in_pos(lk_dp),
    .partner_serial_in_neg(lk_dn), .serial_shift_clock_out_pos(sc_p), .serial_shift_clock_out_neg(sc_n),
    .serial_stream_out_pos(sd_p), .serial_stream_out_neg(sd_n));
  stereo_partner partner_u (.clk_pos(lk_cp), .clk_neg(lk_cn), .dat_pos(lk_dp), .dat_neg(lk_dn));
  // system clock, 10 ns period
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // expected pixel word: top ten bits of the sample (mode 1) or the companding curve (mode 2)
  function automatic logic [9:0] exp_word(input logic [11:0] x, input int m);
    int v;
    v = int'(x);
    if (m == 1) return x[11:2];
    if (v < 256) return 10'(v);
    if (v < 1024) return 10'(256 + (v - 256) / 2);
    return 10'(640 + (v - 1024) / 8);
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // register write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, dd;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ad = 0;
    dd = 0;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
  endtask
  // register read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  // wait for whole frames, then check the last row and frame sizes
  task automatic frame_chk(input int w, input int h);
    f = frames;
    while (frames < f + 2) @(posedge aclk);
    chk("row_words", w, row_words);
    chk("frame_rows", h, frame_rows);
  endtask
  task automatic wait_fq();
    n = 0;
    while (pixel_out.frame_qual !== 1'b1) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // sample source changes every cycle
  always @(posedge aclk) adc_sample <= adc_sample + 12'h00D;
  // port monitor: pixel clock, word timing, capture, sync and serial stream
  always @(posedge aclk) begin
    if (mon_on) begin
      chk("pclk_toggle", !p_pclk, pixel_clock_out);
      chk("word_timing", 1, pixel_out === p_pix || (p_pclk === 1'b1 && pixel_clock_out === 1'b0));
      if (word_mode != 0 && p_pclk === 1'b1 && pixel_clock_out === 1'b0 && pixel_out.row_qual === 1'b1) begin
        chk("pixel_word", exp_word(p_adc, word_mode), pixel_out.pixel_word_bus);
      end
      if (array_dark === 1'b1) dark_seen = 1'b1;
      if (pixel_clock_out && pixel_out.frame_qual && pixel_out.row_qual) wc++;
      if (p_pix.row_qual && !pixel_out.row_qual) begin
        row_words = wc;
        wc = 0;
        rc++;
      end
      if (p_pix.frame_qual && !pixel_out.frame_qual) begin
        frame_rows = rc;
        rc = 0;
        frames++;
      end
      if (sync_out.frame_start_sync && !p_sync.frame_start_sync) fs_pulses++;
      if (sc_p && !p_ssc) begin
        ser_word = {ser_word[14:0], sd_p};
        ser_bits++;
      end
    end
    p_pclk = pixel_clock_out;
    p_pix = pixel_out;
    p_sync = sync_out;
    p_ssc = sc_p;
    p_adc = adc_sample;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    test_done();
  end
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, standby, exposure, mon_on} = '0;
    {bus_id_select_0, bus_id_select_1, sync_in, adc_sample, ser_word, dark_seen} = '0;
    word_mode = 0;
    {clk_en, bready, rready, output_drive_en, wstrb} = '1;
    cyc(10);
    aresetn <= 1'b1;
    cyc(5);
    mon_on <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_write(rows[i].a, rows[i].d, rs);
        chk("bresp", rows[i].rs, rs);
      end else begin
        axi_read(rows[i].a, rd, rs);
        chk("rdata", rows[i].rd, rd);
        chk("rresp", rows[i].rs, rs);
      end
    end
    word_mode = 1;
    frame_chk(COLS, ROWS);
    word_mode = 0;
    chk("sync_oe", 2'b11, sync_oe);
    chk("fs_pulses", 1, fs_pulses > 0);
    axi_write(`OFS_CTRL, 32'h00000010, rs);
    word_mode = 2;
    frame_chk(COLS, ROWS);
    word_mode = 0;
    axi_write(`OFS_CTRL, 32'h0000000C, rs);
    frame_chk(COLS + 36, ROWS + 3);
    chk("array_dark", 1, dark_seen);
    output_drive_en <= 1'b0;
    cyc(5);
    chk("pixel_out_en", 0, pixel_out_en);
    output_drive_en <= 1'b1;
    cyc(5);
    chk("pixel_out_en", 1, pixel_out_en);
    for (int v = 0; v < 4; v++) begin
      {bus_id_select_1, bus_id_select_0} <= 2'(v);
      cyc(4);
      chk("bus_id", ID_BASE | 7'(v), bus_id);
    end
    standby <= 1'b1;
    cyc(8);
    chk("standby_fq", 0, pixel_out.frame_qual);
    f = frames;
    cyc(400);
    chk("standby_frames", f, frames);
    standby <= 1'b0;
    axi_write(`OFS_CTRL, 32'h00000001, rs);
    cyc(1200);
    f = frames;
    cyc(400);
    chk("snap_idle", f, frames);
    exposure <= 1'b1;
    wait_fq();
    chk("snap_start", 1, n < 40);
    exposure <= 1'b0;
    axi_write(`OFS_CTRL, 32'h00000002, rs);
    cyc(400);
    chk("sync_oe_slave", 0, sync_oe);
    sync_in.frame_start_sync <= 1'b1;
    wait_fq();
    chk("slave_start", 1, n < 40);
    sync_in.frame_start_sync <= 1'b0;
    axi_write(`OFS_CTRL, 32'h00000020, rs);
    ser_bits = 0;
    partner_u.send(8'hA5);
    while (ser_bits < 16) @(posedge aclk);
    chk("ser_partner", 8'hA5, ser_word[7:0]);
    cyc(6);
    chk("ser_idle", 2'b01, {sc_p, sc_n});
    chk("ser_neg", !sd_p, sd_n);
    chk("error_out", 0, error_out);
    mon_on <= 1'b0;
    aresetn <= 1'b0;
    #2;
    chk("async_reset", 0, pixel_out_en);
    chk("async_reset_pos", 0, {array_dark, array_col, array_row});
    cyc(10);
    aresetn <= 1'b1;
    axi_read(`OFS_CTRL, rd, rs);
    chk("ctrl_after_reset", 0, rd);
    test_done();
  end
endmodule
